// ### rtl/sector_routing.sv
// routing fabric of a 16 x 16 cell array with per-column clock selection
// assumes cells share clk; global clock arrives asynchronously on a pin
// Function
// [RL1] repeaters split every bus into eight-cell segments
// [RL2] two vertical, two horizontal local buses each
// [RL3] segment reaches every cell in its line; here only the eight cells of its sector
// [RL4] cells turn corners a-to-a and b-to-b
// [RL5] express buses paired, never touching cells
// [RL6] repeater holds one of twenty-one functions
// [RL7] isolate, local, express and transfer joins
// [RL8] repeater joins drive one direction only
// [RL9] b repeaters offer bidirectional local link
// [RL10] read needs pass gate plus mux select
// [RL11] write needs bus and driver gates
// [RL12] driver enable: always on or from b
// [RL13] turn enables both buses' pass gates
// [RL14] each bus serves one operation only
// [RL15] all four cell sides behave alike
// [RL16] each column has its own clock mux
// [RL17] clock from global, express, cell, one
// [RL18] constant one stops the column clock
// [RL19] global clock enters upper corner cells
// [RL20] flip-flops change on rising clock edge
// [RL21] settings held static while array runs
`timescale 1ns/1ps
`default_nettype none
module sector_routing
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // avalon-mm register slave
   input wire logic [8:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // cell array side, index row*16+col
   input wire logic [255:0] cell_out,
   input wire logic [255:0] cell_b,
   output logic [255:0] cell_rd,
   // clock pin and column clocks
   input wire logic global_clock,
   output logic upper_left_corner_input,
   output logic upper_right_corner_input,
   output wire logic [15:0] col_clock,
   output wire logic [15:0] col_rise
);
   // ----------------------------------------------------------------
   // configuration storage
   // ----------------------------------------------------------------
   logic [8:0] cell_cfg [0:255];
   logic [5:0] rep_cfg [0:63];
   logic [1:0] clk_sel [0:15];
   logic run;
   logic [2:0] kind;
   logic [31:0] wmask;
   logic cfg_we;
   logic rd_done;
   logic [31:0] next_rdata;
   logic gclk_m;
   logic gclk_s;
   logic [255:0] next_rd;

   // segment state, index [bus][line][sector]
   wire loc_q [0:3][0:15][0:1];
   wire exp_q [0:3][0:15][0:1];
   wire loc_drv [0:3][0:15][0:1];
   wire loc_val [0:3][0:15][0:1];

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // cell on bus t, line l, sector s, position k
   function automatic int cell_at(input int t, input int l,
      input int s, input int k);
      if (t < 2)
         return (s * route_pkg::SECT + k) * route_pkg::DIM + l;
      else
         return l * route_pkg::DIM + s * route_pkg::SECT + k;
   endfunction

   function automatic logic [1:0] bus_mode(input logic [8:0] c,
      input int t);
      return c[route_pkg::MODE_W * t +: route_pkg::MODE_W];
   endfunction

   // level of bus t as seen from cell i; same rule for every side
   function automatic logic bus_at(input int t, input int i);
      int row;
      int col;
      row = i / route_pkg::DIM;
      col = i % route_pkg::DIM;
      if (t < 2)
         return loc_q[t][col][row / route_pkg::SECT];
      else
         return loc_q[t][row][col / route_pkg::SECT];
   endfunction

   // repeater function table: bit0 l0>l1 bit1 e0>l1 bit2 l0>e1
   // bit3 e0>e1 bit4 l1>l0 bit5 e1>l0 bit6 l1>e0 bit7 e1>e0
   function automatic logic [7:0] rep_mask(input logic [4:0] f);
      case (f)
         5'h01: return 8'h01;
         5'h02: return 8'h08;
         5'h03: return 8'h04;
         5'h04: return 8'h02;
         5'h05: return 8'h10;
         5'h06: return 8'h80;
         5'h07: return 8'h40;
         5'h08: return 8'h20;
         5'h09: return 8'h09;
         5'h0A: return 8'h90;
         5'h0B: return 8'h81;
         5'h0C: return 8'h18;
         5'h0D: return 8'h05;
         5'h0E: return 8'h0A;
         5'h0F: return 8'h50;
         5'h10: return 8'hA0;
         5'h11: return 8'h06;
         5'h12: return 8'h60;
         5'h13: return 8'h44;
         5'h14: return 8'h22;
         default: return 8'h00; // code 0 and unused codes isolate
      endcase
   endfunction

   function automatic logic [2:0] reg_kind(input logic [8:0] a);
      if (a < route_pkg::REP_BASE)
         return route_pkg::K_CELL;
      else if (a < route_pkg::CLK_BASE)
         return route_pkg::K_REP;
      else if (a < route_pkg::STAT_ADDR)
         return route_pkg::K_CLK;
      else if (a == route_pkg::STAT_ADDR)
         return route_pkg::K_STAT;
      else if (a == route_pkg::RUN_ADDR)
         return route_pkg::K_RUN;
      else
         return route_pkg::K_NONE;
   endfunction

   // ----------------------------------------------------------------
   // register slave
   // ----------------------------------------------------------------
   // decode and byte lane mask
   always_comb
   begin
      kind = reg_kind(avs_address);
      wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
         {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      cfg_we = avs_write && !run && (kind == route_pkg::K_CELL ||
         kind == route_pkg::K_REP || kind == route_pkg::K_CLK); // [RL21]
   end

   // writes never stall; reads take one wait cycle for registered data
   assign avs_waitrequest = avs_read && !rd_done;

   // cell words: one mode field per bus, so no bus does two jobs
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < route_pkg::NCELL; i++)
            cell_cfg[i] <= route_pkg::CFG_RST;
      end
      else if (cfg_we && kind == route_pkg::K_CELL)
      begin
         cell_cfg[avs_address[7:0]] <= (cell_cfg[avs_address[7:0]] &
            ~wmask[8:0]) | (avs_writedata[8:0] & wmask[8:0]); // [RL14]
      end
   end

   // repeater words: function code plus bidirectional link enable
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < route_pkg::NREP; i++)
            rep_cfg[i] <= route_pkg::REP_RST;
      end
      else if (cfg_we && kind == route_pkg::K_REP)
      begin
         rep_cfg[avs_address[5:0]] <= (rep_cfg[avs_address[5:0]] &
            ~wmask[5:0]) | (avs_writedata[5:0] & wmask[5:0]); // [RL6]
      end
   end

   // column clock source selects
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < route_pkg::DIM; i++)
            clk_sel[i] <= route_pkg::CK_RST;
      end
      else if (cfg_we && kind == route_pkg::K_CLK)
      begin
         clk_sel[avs_address[3:0]] <= (clk_sel[avs_address[3:0]] &
            ~wmask[1:0]) | (avs_writedata[1:0] & wmask[1:0]); // [RL16]
      end
   end

   // run bit; settings are frozen while it is set
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         run <= route_pkg::RUN_RST;
      else if (avs_write && kind == route_pkg::K_RUN && avs_byteenable[0])
         run <= avs_writedata[0]; // [RL21]
   end

   // read multiplexer
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      case (kind)
         route_pkg::K_CELL:
            next_rdata[8:0] = cell_cfg[avs_address[7:0]];
         route_pkg::K_REP:
            next_rdata[5:0] = rep_cfg[avs_address[5:0]];
         route_pkg::K_CLK:
            next_rdata[1:0] = clk_sel[avs_address[3:0]];
         route_pkg::K_STAT:
            next_rdata[15:0] = col_clock;
         route_pkg::K_RUN:
            next_rdata[0] = run;
         default:
            next_rdata = 32'h0000_0000;
      endcase
   end

   // read data lands one edge after the request, with waitrequest low
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         rd_done <= 1'b0;
         avs_readdata <= 32'h0000_0000;
      end
      else
      begin
         rd_done <= avs_read && !rd_done;
         if (avs_read && !rd_done)
            avs_readdata <= next_rdata;
      end
   end

   // ----------------------------------------------------------------
   // bus segments and repeaters
   // ----------------------------------------------------------------
   // a segment's value is registered each cycle, so turns and repeaters
   // read last cycle's value and no combinational loop can form
   for (genvar t = 0; t < route_pkg::NBUS; t++)
   begin : g_bus
      for (genvar l = 0; l < route_pkg::DIM; l++)
      begin : g_line
         for (genvar s = 0; s < route_pkg::NSEG; s++)
         begin : g_seg
            logic d;
            logic v;
            logic ed;
            logic ev;
            logic lq;
            logic eq;
            logic [7:0] rm;

            // drivers onto this local and express segment
            always_comb
            begin
               int i;
               i = 0;
               d = 1'b0;
               v = 1'b0;
               rm = rep_mask(rep_cfg[t * route_pkg::DIM + l][4:0]);
               for (int k = 0; k < route_pkg::SECT; k++)
               begin
                  i = cell_at(t, l, s, k); // [RL3]
                  // bus gate and driver gate, enable from mode bit
                  if (bus_mode(cell_cfg[i], t) == route_pkg::M_WRITE &&
                     (!cell_cfg[i][route_pkg::DRV_DYN_BIT] || cell_b[i]))
                  begin
                     d = 1'b1; // [RL11] [RL12]
                     v = v | cell_out[i];
                  end
                  // turn only when both paired buses open their gates
                  if (bus_mode(cell_cfg[i], t) == route_pkg::M_TURN &&
                     bus_mode(cell_cfg[i], t ^ 2) == route_pkg::M_TURN)
                  begin
                     d = 1'b1; // [RL4] [RL13]
                     v = v | bus_at(t ^ 2, i);
                  end
               end
               // repeater feeds from the far side only, regenerated
               if ((s == 1) ? rm[0] : rm[4])
               begin
                  d = 1'b1; // [RL7] [RL8]
                  v = v | loc_q[t][l][1 - s];
               end
               if ((s == 1) ? rm[1] : rm[5])
               begin
                  d = 1'b1; // [RL7]
                  v = v | exp_q[t][l][1 - s];
               end
               // express segments see repeaters only, never cells
               ed = (s == 1) ? (rm[2] | rm[3]) : (rm[6] | rm[7]); // [RL5]
               ev = ((s == 1) ? rm[2] : rm[6]) & loc_q[t][l][1 - s];
               ev = ev | (((s == 1) ? rm[3] : rm[7]) & exp_q[t][l][1 - s]);
            end

            // segment keeper; b buses may merge both sides into one net
            always_ff @(posedge clk)
            begin
               if (!rst_n || !run)
               begin
                  lq <= 1'b0;
                  eq <= 1'b0;
               end
               else
               begin
                  if ((t % 2) == 1 &&
                     rep_cfg[t * route_pkg::DIM + l][route_pkg::REP_BIDIR_BIT]
                     && (loc_drv[t][l][0] || loc_drv[t][l][1]))
                     lq <= loc_val[t][l][0] | loc_val[t][l][1]; // [RL9]
                  else if (d)
                     lq <= v; // [RL1]
                  if (ed)
                     eq <= ev;
               end
            end

            assign loc_drv[t][l][s] = d;
            assign loc_val[t][l][s] = v;
            assign loc_q[t][l][s] = lq; // [RL2]
            assign exp_q[t][l][s] = eq; // [RL5]
         end
      end
   end

   // ----------------------------------------------------------------
   // cell read path
   // ----------------------------------------------------------------
   // lowest numbered bus in read mode feeds the cell's input mux
   always_comb
   begin
      next_rd = '0;
      for (int i = 0; i < route_pkg::NCELL; i++)
      begin
         for (int t = route_pkg::NBUS - 1; t >= 0; t--)
         begin
            if (bus_mode(cell_cfg[i], t) == route_pkg::M_READ)
               next_rd[i] = bus_at(t, i); // [RL10] [RL15]
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
         cell_rd <= '0;
      else
         cell_rd <= next_rd;
   end

   // ----------------------------------------------------------------
   // global clock pin and column clocks
   // ----------------------------------------------------------------
   // pin is asynchronous; two flops before any use
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         gclk_m <= 1'b0;
         gclk_s <= 1'b0;
      end
      else
      begin
         gclk_m <= global_clock;
         gclk_s <= gclk_m;
      end
   end

   // corner cells see the synchronised pin directly
   always_comb
   begin
      upper_left_corner_input = gclk_s; // [RL19]
      upper_right_corner_input = gclk_s;
   end

   // express source is vertical express a at the top sector
   for (genvar c = 0; c < route_pkg::DIM; c++)
   begin : g_col
      col_clock_select u_sel
      (
         .clk(clk),
         .rst_n(rst_n),
         .sel(clk_sel[c]),
         .src_global(gclk_s),
         .src_express(exp_q[0][c][0]),
         .src_cell(cell_out[c]),
         .col_clk(col_clock[c]),
         .col_rise(col_rise[c])
      ); // [RL16] [RL17]
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_frozen_config : assert property ( // [RL21]
      @(posedge clk) disable iff (!rst_n)
      run |=> $stable(cell_cfg[0]) && $stable(rep_cfg[0]) &&
      $stable(clk_sel[0])
   ) else $error("configuration changed while running");

   a_write_drives : assert property ( // [RL11]
      @(posedge clk) disable iff (!rst_n)
      run && bus_mode(cell_cfg[0], 0) == route_pkg::M_WRITE &&
      (!cell_cfg[0][route_pkg::DRV_DYN_BIT] || cell_b[0]) && cell_out[0]
      |=> !run || loc_q[0][0][0]
   ) else $error("active driver failed to set its segment");

   a_read_path : assert property ( // [RL10]
      @(posedge clk) disable iff (!rst_n)
      bus_mode(cell_cfg[48], 0) == route_pkg::M_READ
      |=> cell_rd[48] == $past(loc_q[0][0][0])
   ) else $error("cell read does not reflect its bus");

   a_turn_corner : assert property ( // [RL13]
      @(posedge clk) disable iff (!rst_n)
      run && bus_mode(cell_cfg[48], 0) == route_pkg::M_TURN &&
      bus_mode(cell_cfg[48], 2) == route_pkg::M_TURN && loc_q[0][0][0]
      |=> !run || loc_q[2][3][0]
   ) else $error("corner turn did not pass the level");

   a_repeater_fwd : assert property ( // [RL8]
      @(posedge clk) disable iff (!rst_n)
      run && rep_cfg[0][4:0] == 5'h01 && loc_q[0][0][0]
      |=> !run || loc_q[0][0][1]
   ) else $error("forward repeater did not regenerate");

   a_stopped_quiet : assert property ( // [RL21]
      @(posedge clk) disable iff (!rst_n)
      !run |=> !loc_q[0][0][0] && !exp_q[0][0][0]
   ) else $error("segment active while array stopped");
endmodule
`default_nettype wire

// ### rtl/route_pkg.sv
// shared constants for the sector routing fabric and its column clocks
// assumes a 16 x 16 cell array, word-addressed avalon-mm slave
package route_pkg;
   // ----------------------------------------------------------------
   // array geometry
   // ----------------------------------------------------------------
   localparam int DIM = 16; // cells per row and per column
   localparam int SECT = 8; // cells spanned by one bus segment
   localparam int NSEG = DIM / SECT;
   localparam int NCELL = DIM * DIM;
   localparam int NBUS = 4; // vert a, vert b, horiz a, horiz b
   localparam int NREP = NBUS * DIM;
   // ----------------------------------------------------------------
   // cell configuration word
   // ----------------------------------------------------------------
   localparam int CFG_W = 9;
   localparam int MODE_W = 2; // two mode bits per bus, bus t at 2*t
   localparam int DRV_DYN_BIT = 8; // 1: driver enable taken from b
   localparam logic [1:0] M_OFF = 2'h0;
   localparam logic [1:0] M_READ = 2'h1;
   localparam logic [1:0] M_WRITE = 2'h2;
   localparam logic [1:0] M_TURN = 2'h3;
   localparam logic [8:0] CFG_RST = 9'h000;
   // ----------------------------------------------------------------
   // repeater configuration word
   // ----------------------------------------------------------------
   localparam int REP_W = 6;
   localparam int REP_FN_W = 5;
   localparam int REP_BIDIR_BIT = 5;
   localparam logic [5:0] REP_RST = 6'h00;
   // ----------------------------------------------------------------
   // column clock source codes
   // ----------------------------------------------------------------
   localparam logic [1:0] CK_GLOBAL = 2'h0;
   localparam logic [1:0] CK_EXPRESS = 2'h1;
   localparam logic [1:0] CK_CELL = 2'h2;
   localparam logic [1:0] CK_ONE = 2'h3;
   localparam logic [1:0] CK_RST = 2'h3;
   // ----------------------------------------------------------------
   // register map, word addresses
   // ----------------------------------------------------------------
   localparam int ADDR_W = 9;
   localparam logic [8:0] CELL_BASE = 9'h000;
   localparam logic [8:0] REP_BASE = 9'h100;
   localparam logic [8:0] CLK_BASE = 9'h140;
   localparam logic [8:0] STAT_ADDR = 9'h150;
   localparam logic [8:0] RUN_ADDR = 9'h151;
   localparam logic RUN_RST = 1'b0;
   localparam logic [2:0] K_NONE = 3'h0;
   localparam logic [2:0] K_CELL = 3'h1;
   localparam logic [2:0] K_REP = 3'h2;
   localparam logic [2:0] K_CLK = 3'h3;
   localparam logic [2:0] K_STAT = 3'h4;
   localparam logic [2:0] K_RUN = 3'h5;
endpackage

// ### rtl/col_clock_select.sv
// one column clock multiplexer with rising edge detection
// assumes all sources are already synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module col_clock_select
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // source selection
   input wire logic [1:0] sel,
   input wire logic src_global,
   input wire logic src_express,
   input wire logic src_cell,
   // column clock
   output logic col_clk,
   output logic col_rise
);
   // ----------------------------------------------------------------
   // source multiplexer
   // ----------------------------------------------------------------
   logic next_clk;

   // constant one holds the column still, saving its toggling power
   always_comb
   begin
      case (sel)
         route_pkg::CK_GLOBAL: next_clk = src_global; // [RL17]
         route_pkg::CK_EXPRESS: next_clk = src_express;
         route_pkg::CK_CELL: next_clk = src_cell;
         default: next_clk = 1'b1; // [RL18]
      endcase
   end

   // registered column level; reset high so a stopped column never ticks
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         col_clk <= 1'b1;
         col_rise <= 1'b0;
      end
      else
      begin
         col_clk <= next_clk;
         col_rise <= next_clk & ~col_clk; // [RL20]
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_held_one;
      (sel == route_pkg::CK_ONE) [*2];
   endsequence

   a_const_stops_clock : assert property ( // [RL18]
      @(posedge clk) disable iff (!rst_n)
      s_held_one |=> !col_rise
   ) else $error("column ticked while held at constant one");

   a_global_follows : assert property ( // [RL17]
      @(posedge clk) disable iff (!rst_n)
      sel == route_pkg::CK_GLOBAL |=> col_clk == $past(src_global)
   ) else $error("column clock does not follow global source");

   a_rise_on_edge : assert property ( // [RL20]
      @(posedge clk) disable iff (!rst_n)
      $rose(col_clk) |-> col_rise ##1 !col_rise
   ) else $error("rising column edge not marked by one pulse");
endmodule
`default_nettype wire

// ### testbench/cell_nbr.sv
// neighbouring cells and the external clock source
// assumes the bench changes levels just after rising clk edges
`timescale 1ns/1ps
`default_nettype none
module cell_nbr
(
   // bench control
   input wire logic clk,
   input wire logic [255:0] a_level,
   input wire logic [255:0] b_level,
   input wire logic gclk_run,
   // toward the fabric
   output logic [255:0] cell_out,
   output logic [255:0] cell_b,
   output logic global_clock
);
   logic [3:0] div = 4'h0;
   // cells present outputs synchronously, like real array cells
   always_ff @(posedge clk)
   begin
      cell_out <= a_level;
      cell_b <= b_level;
   end
   // slow pin clock; stands low when stopped, not at its last level
   always_ff @(posedge clk)
   begin
      div <= div + 4'h1;
      if (!gclk_run)
         global_clock <= 1'b0;
      else if (div == 4'hF)
         global_clock <= ~global_clock;
   end
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the routing fabric
// assumes route_pkg and sector_routing compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [8:0] adr = 9'h000;
   logic rd_q = 1'b0;
   logic wr_q = 1'b0;
   logic [31:0] wd = 32'h0000_0000;
   logic [31:0] rdata;
   logic wait_q;
   logic [255:0] a_lv = {256{1'b0}};
   logic [255:0] b_lv = {256{1'b0}};
   logic [255:0] c_out;
   logic [255:0] c_b;
   logic [255:0] c_rd;
   logic gk_run = 1'b0;
   logic gk;
   logic ulc;
   logic urc;
   wire [15:0] col_ck;
   wire [15:0] rise;
   logic [31:0] v;
   int err_total = 0;
   int comparisons = 0;
   int cyc = 0;
   int n0;
   int n1;
   int hi;
   // ------------------------------------------------
   // clock, units and timeout
   // ------------------------------------------------
   always #2.5 clk = ~clk;
   sector_routing dut (.clk(clk), .rst_n(rst_n), .avs_address(adr),
      .avs_read(rd_q), .avs_write(wr_q), .avs_writedata(wd),
      .avs_byteenable(4'hF), .avs_readdata(rdata),
      .avs_waitrequest(wait_q), .cell_out(c_out), .cell_b(c_b),
      .cell_rd(c_rd), .global_clock(gk), .upper_left_corner_input(ulc),
      .upper_right_corner_input(urc), .col_clock(col_ck), .col_rise(rise));
   cell_nbr nbr (.clk(clk), .a_level(a_lv), .b_level(b_lv),
      .gclk_run(gk_run), .cell_out(c_out), .cell_b(c_b), .global_clock(gk));
   // a hang counts as a mismatch
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 5000)
      begin
         err_total++;
         complete_run;
      end
   end
   // ------------------------------------------------
   // tasks
   // ------------------------------------------------
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e)
      begin
         $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
         err_total++;
      end
   endtask
   // waitrequest is read at the rising edge, before that edge updates it
   task automatic wr(input logic [8:0] a, input logic [31:0] d);
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr_q <= 1'b1;
      @(posedge clk);
      while (wait_q !== 1'b0)
         @(posedge clk);
      wr_q <= 1'b0;
   endtask
   task automatic rd(input logic [8:0] a, output logic [31:0] d);
      @(posedge clk);
      adr <= a;
      rd_q <= 1'b1;
      @(posedge clk);
      while (wait_q !== 1'b0)
         @(posedge clk);
      d = rdata;
      rd_q <= 1'b0;
   endtask
   task automatic wait_rd(input int i);
      repeat (20)
      begin
         @(negedge clk);
         if (c_rd[i] === 1'b1)
            break;
      end
      chk({31'h0, c_rd[i]}, 32'h1);
   endtask
   // ------------------------------------------------
   // tests
   // ------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd(route_pkg::STAT_ADDR, v);
      chk(v, 32'h0000_FFFF);
      rd(route_pkg::CLK_BASE, v);
      chk(v, {30'h0, route_pkg::CK_RST});
      wr(9'h152, 32'hFFFF_FFFF);
      rd(9'h152, v);
      chk(v, 32'h0000_0000);
      $display("test registers done");
      // dynamic driver with b low, one op per bus
      wr(9'h000, 32'h0000_0102);
      wr(9'h030, 32'h0000_0001);
      wr(9'h090, 32'h0000_0001);
      wr(route_pkg::RUN_ADDR, 32'h1);
      a_lv[0] <= 1'b1;
      repeat (8) @(negedge clk);
      chk({31'h0, c_rd[48]}, 32'h0);
      @(posedge clk);
      b_lv[0] <= 1'b1;
      wait_rd(48);
      chk({31'h0, c_rd[144]}, 32'h0);
      wr(route_pkg::REP_BASE, 32'h1);
      rd(route_pkg::REP_BASE, v);
      chk(v, 32'h0000_0000);
      wr(route_pkg::RUN_ADDR, 32'h0);
      wr(route_pkg::REP_BASE, 32'h1);
      wr(9'h030, 32'h0000_0033);
      wr(9'h035, 32'h0000_0010);
      wr(route_pkg::RUN_ADDR, 32'h1);
      wait_rd(144);
      wait_rd(53);
      // b link carries a level back across its isolating repeater
      wr(route_pkg::RUN_ADDR, 32'h0);
      wr(9'h110, 32'h0000_0020);
      wr(9'h090, 32'h0000_0008);
      wr(9'h030, 32'h0000_0037);
      a_lv[144] <= 1'b1;
      wr(route_pkg::RUN_ADDR, 32'h1);
      wait_rd(48);
      $display("test routing done");
      wr(route_pkg::RUN_ADDR, 32'h0);
      wr(route_pkg::CLK_BASE, {30'h0, route_pkg::CK_GLOBAL});
      wr(9'h142, {30'h0, route_pkg::CK_CELL});
      wr(9'h143, {30'h0, route_pkg::CK_EXPRESS});
      wr(9'h103, 32'h0000_0007);
      wr(9'h083, 32'h0000_0002);
      wr(route_pkg::RUN_ADDR, 32'h1);
      gk_run <= 1'b1;
      n0 = 0;
      n1 = 0;
      hi = 0;
      repeat (200)
      begin
         @(negedge clk);
         n0 += int'(rise[0]);
         n1 += int'(rise[1]) + int'(ulc !== urc);
         hi += int'(ulc & urc);
      end
      chk({31'h0, n0 >= 3}, 32'h1);
      chk(n1, 32'h0);
      chk({31'h0, hi > 0 && hi < 200}, 32'h1);
      chk({30'h0, col_ck[3:2]}, 32'h0);
      @(posedge clk);
      a_lv[2] <= 1'b1;
      a_lv[131] <= 1'b1;
      n0 = 0;
      n1 = 0;
      repeat (10)
      begin
         @(negedge clk);
         n0 += int'(rise[2]);
         n1 += int'(rise[3]);
      end
      chk(n0, 32'h1);
      chk(n1, 32'h1);
      $display("test clocks done");
      complete_run;
   end
endmodule
`default_nettype wire
